// File: pkg/gds_map.svh
`ifndef GDS_MAP_SVH
`define GDS_MAP_SVH
// Register and command addresses
`define GDS_ADDR_LPF_CFG 8'h02
`define GDS_ADDR_RATE_CFG 8'h03
`define GDS_ADDR_STATUS 8'h04
`define GDS_ADDR_SLEEP_IN 8'h05
`define GDS_ADDR_SLEEP_OUT 8'h06
`define GDS_ADDR_STANDBY 8'h07
`define GDS_ADDR_SW_RESET 8'h09
// Reset values and writable-bit masks
`define GDS_LPF_CFG_RST 8'h06
`define GDS_LPF_CFG_WMASK 8'h3f
`define GDS_RATE_CFG_RST 8'h00
`define GDS_RATE_CFG_WMASK 8'h67
// Field positions
`define GDS_ORDER_MSB 5
`define GDS_ORDER_LSB 4
`define GDS_CUTOFF_MSB 3
`define GDS_CUTOFF_LSB 0
`define GDS_DECIM_MSB 2
`define GDS_DECIM_LSB 0
`define GDS_STS_TEMP_BIT 3
// Prior power state codes
`define GDS_PRIOR_POWERUP 3'h4
`define GDS_PRIOR_STANDBY 3'h2
`define GDS_PRIOR_SLEEP 3'h0
`define GDS_PRIOR_WAKE 3'h1
// Sample width
`define GDS_SMP_W 24
`endif

// File: pkg/gds_pkg.sv
`include "gds_map.svh"
package gds_pkg;
  typedef enum logic [1:0] {
    GDS_PWR_ACTIVE,
    GDS_PWR_SLEEP,
    GDS_PWR_STANDBY
  } gds_pwr_e;

  typedef struct packed {
    logic [1:0] lowpass_order_sel;
    logic [3:0] lowpass_cutoff_sel;
    logic [2:0] output_decimation_sel;
  } gds_cfg_s;

  typedef struct packed {
    logic valid;
    logic [`GDS_SMP_W-1:0] data;
  } gds_smp_s;
endpackage

// File: verilog/gds_decimator.sv
`timescale 1ns/1ps
`include "gds_map.svh"
module gds_decimator (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic [2:0] i_decim_sel,
  input wire gds_pkg::gds_smp_s i_smp,
  output gds_pkg::gds_smp_s o_smp
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] mask;
  gds_pkg::gds_smp_s smp_q;
  gds_pkg::gds_smp_s smp_d;

  always_comb begin
    mask = 7'((8'h01 << i_decim_sel) - 8'h01);
    cnt_d = cnt_q;
    smp_d.valid = 1'b0;
    smp_d.data = smp_q.data;
    if (i_clear || !i_run) begin
      cnt_d = 7'h00;
    end else if (i_smp.valid) begin
      // Keep the first sample of each interval of 2^sel input samples
      if ((cnt_q & mask) == 7'h00) begin
        smp_d.valid = 1'b1;
        smp_d.data = i_smp.data;
      end
      cnt_d = (cnt_q + 7'h01) & mask;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 7'h00;
      smp_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      smp_q <= smp_d;
    end
  end

  assign o_smp = smp_q;

  decim_spacing_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_decim_sel == 3'h1 && !i_clear && i_run && i_smp.valid && cnt_q == 7'h01
     ##1 i_decim_sel == 3'h1 && !i_clear && i_run && i_smp.valid) |=> o_smp.valid)
    else $error("decimate by two did not pass every second sample");

  decim_data_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_smp.valid |-> (o_smp.data == $past(i_smp.data) && $past(i_smp.valid) && $past(i_run)))
    else $error("decimated sample is not the accepted input sample");

  clear_count_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clear |=> (cnt_q == 7'h00 && !o_smp.valid))
    else $error("filter reset did not restart the decimation count");
endmodule

// File: verilog/gds_cfg_status_regs.sv
`timescale 1ns/1ps
`include "gds_map.svh"
// Notes on behaviour
// - Order code 01 gives third order, 10 fourth order, 11 is unavailable and 00 is the second-order setting.
// - The four-bit cutoff code selects 35 Hz (0001) up to 500 Hz (1101), and 1110 and 1111 are unavailable.
// - The output sample rate is the converter rate divided by two to the power of the three-bit decimation code.
// - The output stream is made by keeping one converter sample in each decimation interval.
// - Bit 3 of the status register at 0x04 reads 1 when temperature data is available in the active state, and 0 otherwise, including in sleep and standby.
// - Status bits 2 to 0 read 100 after power-on, 010 after standby, 000 after sleep and 001 after sleep-out.
// - The sleep-out command at 0x06 leaves sleep or standby, resumes operation and resets the filter chain.
// - The software reset command at 0x09 returns the filter and decimation settings to their defaults.
module gds_cfg_status_regs (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_reg_cmd,
  input wire logic i_temp_ready,
  input wire gds_pkg::gds_smp_s i_adc_smp,
  output logic [7:0] o_reg_rdata,
  output gds_pkg::gds_cfg_s o_cfg,
  output logic o_dsp_reset,
  output logic o_detect_en,
  output gds_pkg::gds_smp_s o_rate_smp
);
  logic [7:0] lpf_q;
  logic [7:0] lpf_d;
  logic [7:0] rate_q;
  logic [7:0] rate_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  gds_pkg::gds_cfg_s cfg_q;
  gds_pkg::gds_cfg_s cfg_d;
  gds_pkg::gds_pwr_e pwr_q;
  gds_pkg::gds_pwr_e pwr_d;
  logic [2:0] prior_q;
  logic [2:0] prior_d;
  logic dsp_rst_q;
  logic dsp_rst_d;
  logic detect_q;
  logic detect_d;
  logic temp_valid;
  logic cmd_sleep_in;
  logic cmd_sleep_out;
  logic cmd_standby;
  logic cmd_sw_reset;

  // Merge a write into a register, keeping read-only bits at their current value
  function automatic logic [7:0] merge_wr(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] wmask);
    merge_wr = (cur & ~wmask) | (wd & wmask);
  endfunction

  function automatic logic is_cmd(input logic [7:0] addr, input logic [7:0] code, input logic strobe);
    is_cmd = strobe && (addr == code);
  endfunction

  assign cmd_sleep_in = is_cmd(i_reg_addr, `GDS_ADDR_SLEEP_IN, i_reg_cmd);
  assign cmd_sleep_out = is_cmd(i_reg_addr, `GDS_ADDR_SLEEP_OUT, i_reg_cmd);
  assign cmd_standby = is_cmd(i_reg_addr, `GDS_ADDR_STANDBY, i_reg_cmd);
  assign cmd_sw_reset = is_cmd(i_reg_addr, `GDS_ADDR_SW_RESET, i_reg_cmd);

  // Data availability is forced low while the sensor path is parked
  assign temp_valid = i_temp_ready && (pwr_q == gds_pkg::GDS_PWR_ACTIVE);

  // Configuration registers
  always_comb begin
    lpf_d = lpf_q;
    rate_d = rate_q;
    if (cmd_sw_reset) begin
      lpf_d = `GDS_LPF_CFG_RST;
      rate_d = `GDS_RATE_CFG_RST;
    end else if (is_cmd(i_reg_addr, `GDS_ADDR_LPF_CFG, i_reg_wr)) begin
      lpf_d = merge_wr(lpf_q, i_reg_wdata, `GDS_LPF_CFG_WMASK);
    end else if (is_cmd(i_reg_addr, `GDS_ADDR_RATE_CFG, i_reg_wr)) begin
      rate_d = merge_wr(rate_q, i_reg_wdata, `GDS_RATE_CFG_WMASK);
    end
    cfg_d.lowpass_order_sel = lpf_d[`GDS_ORDER_MSB:`GDS_ORDER_LSB];
    cfg_d.lowpass_cutoff_sel = lpf_d[`GDS_CUTOFF_MSB:`GDS_CUTOFF_LSB];
    cfg_d.output_decimation_sel = rate_d[`GDS_DECIM_MSB:`GDS_DECIM_LSB];
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lpf_q <= `GDS_LPF_CFG_RST;
      rate_q <= `GDS_RATE_CFG_RST;
      cfg_q <= '{lowpass_order_sel: 2'h0, lowpass_cutoff_sel: 4'h6, output_decimation_sel: 3'h0};
    end else begin
      lpf_q <= lpf_d;
      rate_q <= rate_d;
      cfg_q <= cfg_d;
    end
  end

  // Power state and the prior-state code
  always_comb begin
    pwr_d = pwr_q;
    prior_d = prior_q;
    dsp_rst_d = 1'b0;
    case (pwr_q)
      gds_pkg::GDS_PWR_ACTIVE: begin
        if (cmd_sleep_in) begin
          pwr_d = gds_pkg::GDS_PWR_SLEEP;
          prior_d = `GDS_PRIOR_SLEEP;
        end else if (cmd_standby) begin
          pwr_d = gds_pkg::GDS_PWR_STANDBY;
          prior_d = `GDS_PRIOR_STANDBY;
        end
      end
      gds_pkg::GDS_PWR_SLEEP, gds_pkg::GDS_PWR_STANDBY: begin
        // Standby cannot be entered from sleep; only sleep-out leaves either state
        if (cmd_sleep_out) begin
          pwr_d = gds_pkg::GDS_PWR_ACTIVE;
          prior_d = `GDS_PRIOR_WAKE;
          dsp_rst_d = 1'b1;
        end
      end
      default: begin
        pwr_d = gds_pkg::GDS_PWR_ACTIVE;
      end
    endcase
    detect_d = (pwr_d != gds_pkg::GDS_PWR_STANDBY);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwr_q <= gds_pkg::GDS_PWR_ACTIVE;
      prior_q <= `GDS_PRIOR_POWERUP;
      dsp_rst_q <= 1'b0;
      detect_q <= 1'b1;
    end else begin
      pwr_q <= pwr_d;
      prior_q <= prior_d;
      dsp_rst_q <= dsp_rst_d;
      detect_q <= detect_d;
    end
  end

  // Read data, registered one cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `GDS_ADDR_LPF_CFG: begin
          rdata_d = lpf_q;
        end
        `GDS_ADDR_RATE_CFG: begin
          rdata_d = rate_q;
        end
        `GDS_ADDR_STATUS: begin
          rdata_d = {4'h0, temp_valid, prior_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  gds_decimator u_decim (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(dsp_rst_q),
    .i_run(pwr_q == gds_pkg::GDS_PWR_ACTIVE),
    .i_decim_sel(cfg_q.output_decimation_sel),
    .i_smp(i_adc_smp),
    .o_smp(o_rate_smp)
  );

  assign o_reg_rdata = rdata_q;
  assign o_cfg = cfg_q;
  assign o_dsp_reset = dsp_rst_q;
  assign o_detect_en = detect_q;

  order_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_wr && !i_reg_cmd && i_reg_addr == `GDS_ADDR_LPF_CFG) |=> o_cfg.lowpass_order_sel == $past(i_reg_wdata[5:4]))
    else $error("order field did not follow the write");

  cutoff_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_wr && !i_reg_cmd && i_reg_addr == `GDS_ADDR_LPF_CFG) ##1 (!i_reg_wr && !i_reg_cmd)
    |=> o_cfg.lowpass_cutoff_sel == $past(i_reg_wdata[3:0], 2))
    else $error("cutoff field did not hold the written code");

  decim_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_wr && !i_reg_cmd && i_reg_addr == `GDS_ADDR_RATE_CFG) |=> o_cfg.output_decimation_sel == $past(i_reg_wdata[2:0]))
    else $error("decimation field did not follow the write");

  temp_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == `GDS_ADDR_STATUS) |=> o_reg_rdata[3] == $past(i_temp_ready && pwr_q == gds_pkg::GDS_PWR_ACTIVE))
    else $error("temperature flag read back wrong");

  prior_code_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == `GDS_ADDR_STATUS) |=>
    (o_reg_rdata[2:0] inside {3'h4, 3'h2, 3'h0, 3'h1}) && o_reg_rdata[7:4] == 4'h0)
    else $error("status shows an illegal prior-state code");

  sleep_exit_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (cmd_sleep_out && pwr_q != gds_pkg::GDS_PWR_ACTIVE) |=> (o_dsp_reset && prior_q == 3'h1 ##1 !o_dsp_reset))
    else $error("sleep-out did not pulse the filter reset once");

  soft_reset_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_sw_reset |=> (lpf_q == `GDS_LPF_CFG_RST && rate_q == `GDS_RATE_CFG_RST && o_cfg.lowpass_cutoff_sel == 4'h6
    && o_cfg.lowpass_order_sel == 2'h0 && o_cfg.output_decimation_sel == 3'h0))
    else $error("software reset did not restore the defaults");

  standby_detect_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (cmd_standby && pwr_q == gds_pkg::GDS_PWR_ACTIVE) |=> (!o_detect_en && prior_q == 3'h2))
    else $error("standby did not park the detector");

  sleep_enter_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (cmd_sleep_in && pwr_q == gds_pkg::GDS_PWR_ACTIVE) |=> (o_detect_en && prior_q == `GDS_PRIOR_SLEEP))
    else $error("sleep-in did not record the sleep state");

  parked_temp_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == `GDS_ADDR_STATUS && pwr_q != gds_pkg::GDS_PWR_ACTIVE) |=> !o_reg_rdata[3])
    else $error("temperature flag set while parked");
endmodule

// File: sim/gds_host_model.sv
`timescale 1ns/1ps
module gds_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd,
  output logic o_reg_cmd
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
    o_reg_cmd = 1'b0;
  end
  // Kind 0 writes, 1 reads, 2 issues an address-only command
  task automatic acc(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] d;
    d = wd;
    if (a == 8'h02) d[7:6] = 2'h0;
    if (a == 8'h03) d[7:3] = 5'h00;
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= (kind == 2'h0);
    o_reg_rd <= (kind == 2'h1);
    o_reg_cmd <= (kind == 2'h2);
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    o_reg_cmd <= 1'b0;
    // Idle lines carry the inverse so a stale value never looks valid
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
    #1 rd = i_reg_rdata;
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst, temp_rdy, wr, rd, cmd, dsp_rst, det_en;
  logic [7:0] addr, wdata, rdata, rv, last_smp;
  gds_pkg::gds_smp_s adc_smp, rate_smp;
  gds_pkg::gds_cfg_s cfg;
  int fails = 0;
  int checks_done = 0;
  int kept = 0;
  int pulses = 0;
  int k0;
  gds_host_model host (.i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_wdata(wdata), .o_reg_rd(rd), .o_reg_cmd(cmd));
  gds_cfg_status_regs dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .i_reg_cmd(cmd), .i_temp_ready(temp_rdy), .i_adc_smp(adc_smp),
    .o_reg_rdata(rdata), .o_cfg(cfg), .o_dsp_reset(dsp_rst), .o_detect_en(det_en), .o_rate_smp(rate_smp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rate_smp.valid === 1'b1) begin
      kept <= kept + 1;
      last_smp <= rate_smp.data[7:0];
    end
    if (dsp_rst === 1'b1) pulses <= pulses + 1;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.acc(2'h1, a, 8'h00, rv);
    chk(rv, exp);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.acc(2'h0, a, d, rv);
  endtask
  task automatic cmd_issue(input logic [7:0] a);
    host.acc(2'h2, a, 8'h00, rv);
  endtask
  // Back-to-back converter samples, then let the pipeline drain
  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      adc_smp <= '{1'b1, 24'(i)};
    end
    @(posedge clk);
    adc_smp.valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    temp_rdy = 1'b1;
    adc_smp = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h02, 8'h06);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h0c);
    rdchk(8'h0a, 8'h00);
    $display("test reset values done");
    for (int o = 0; o < 3; o++) begin
      for (int c = 1; c < 14; c++) begin
        wr_reg(8'h02, 8'(o * 16 + c));
        chk({2'h0, cfg.lowpass_order_sel, cfg.lowpass_cutoff_sel}, 8'(o * 16 + c));
        rdchk(8'h02, 8'(o * 16 + c));
      end
    end
    $display("test filter codes done");
    for (int d = 0; d < 8; d++) begin
      wr_reg(8'h03, 8'(d));
      chk({5'h00, cfg.output_decimation_sel}, 8'(d));
      k0 = kept;
      feed(128);
      chk(8'(kept - k0), 8'(128 >> d));
      chk(last_smp, 8'(128 - (1 << d)));
    end
    rdchk(8'h03, 8'h07);
    $display("test decimation done");
    wr_reg(8'h03, 8'h00);
    cmd_issue(8'h07);
    chk({7'h00, det_en}, 8'h00);
    rdchk(8'h04, 8'h02);
    k0 = kept;
    feed(16);
    chk(8'(kept - k0), 8'h00);
    cmd_issue(8'h05);
    rdchk(8'h04, 8'h02);
    k0 = pulses;
    cmd_issue(8'h06);
    rdchk(8'h04, 8'h09);
    chk(8'(pulses - k0), 8'h01);
    chk({7'h00, det_en}, 8'h01);
    cmd_issue(8'h06);
    rdchk(8'h04, 8'h09);
    chk(8'(pulses - k0), 8'h01);
    cmd_issue(8'h05);
    cmd_issue(8'h07);
    rdchk(8'h04, 8'h00);
    chk({7'h00, det_en}, 8'h01);
    cmd_issue(8'h06);
    @(posedge clk);
    temp_rdy <= 1'b0;
    rdchk(8'h04, 8'h01);
    $display("test power states done");
    wr_reg(8'h02, 8'h2d);
    wr_reg(8'h03, 8'h05);
    cmd_issue(8'h09);
    chk({2'h0, cfg.lowpass_order_sel, cfg.lowpass_cutoff_sel}, 8'h06);
    chk({5'h00, cfg.output_decimation_sel}, 8'h00);
    rdchk(8'h02, 8'h06);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h01);
    $display("test software reset done");
    close_out;
  end
endmodule
